/* scm_pkg.sv */
/*
 * Shared constants for the serial control DAC loader and output mode logic.
 * Assumes nothing beyond a SystemVerilog compiler; holds definitions only.
 */
package scm_pkg;
   // Width of one serial load word.
   localparam int WORD_W = 12;
   // Width of the saturating serial clock counter.
   localparam int CNT_W = 2;
   // Least number of serial clocks in a valid load cycle.
   localparam logic [1:0] MIN_LOAD_CLKS = 2'h3;
   // Counter value that opens a new word.
   localparam logic [1:0] CNT_FIRST = 2'h1;
   // Bit of the applied word that requests grounding in serial mode.
   localparam int PROG_GND_BIT = 11;
   // Value held by the control DAC after reset.
   localparam logic [11:0] DAC_RST = 12'h000;
   // Value the control DAC shows while forced to analog ground.
   localparam logic [11:0] DAC_GND = 12'h000;
   // Core clock period in nanoseconds.
   localparam int CORE_CLK_NS = 25;
   // Depth of the synchroniser chains.
   localparam int SYNC_STAGES = 2;

   // Modes that decide what drives the outputs.
   typedef enum logic [2:0] {
      SCM_MODE_NORMAL = 3'b001,
      SCM_MODE_PROG_GND = 3'b010,
      SCM_MODE_PIN_GND = 3'b100
   } scm_mode_t;
endpackage

/* scm_sync.sv */
/*
 * Two flip-flop synchroniser with an asynchronous active-low clear.
 * Assumes the clear is a reset whose release may be asynchronous to clk_i.
 */
`timescale 1ns/1ps
module scm_sync
   import scm_pkg::*;
(
   input wire logic clk_i,
   input wire logic clr_n_i,
   input wire logic d_i,
   output logic q_o
);
   logic stage1;
   logic stage2;

   // The first stage feeds only the second stage.
   always_ff @(posedge clk_i or negedge clr_n_i) begin
      if (!clr_n_i) begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
      end else begin
         stage1 <= d_i;
         stage2 <= stage1;
      end
   end

   assign q_o = stage2;
endmodule

/* scm_top.sv */
/*
 * Serial load interface of the control DAC and the pin-driven output mode logic.
 * Assumes a free core clock, a serial clock from the host that may stop outside
 * load cycles, and a load strobe that stays high long enough for the core to see it.
 */
`timescale 1ns/1ps
module scm_top
   import scm_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic serial_clk_i,
   input wire logic serial_load_strobe_i,
   input wire logic serial_data_in_i,
   input wire logic mode_source_select_i,
   input wire logic ground_force_switch_i,
   output logic [11:0] control_dac_output_o,
   output logic analog_ground_o,
   output logic dac_update_o
);
   logic core_rst_n;
   logic link_rst_n;
   logic start_pending;
   logic [11:0] shift_word;
   logic [11:0] next_shift_word;
   logic [1:0] clk_count;
   logic [1:0] next_clk_count;
   logic strobe_low_sync;
   logic strobe_low_prev;
   logic [11:0] dac_word;
   logic [11:0] next_dac_word;
   logic update;
   logic next_update;
   logic strobe_rise;
   scm_mode_t mode;

   // Saturating increment of the serial clock counter.
   function automatic logic [1:0] sat_inc(input logic [1:0] c);
      if (c == MIN_LOAD_CLKS) begin
         return MIN_LOAD_CLKS;
      end
      return 2'(c + 2'h1);
   endfunction

   // Core reset, released through two flip-flops.
   scm_sync u_core_rst (
      .clk_i(core_clk_i),
      .clr_n_i(resetn_i),
      .d_i(1'b1),
      .q_o(core_rst_n)
   );

   // Link reset, released on serial clock edges.
   scm_sync u_link_rst (
      .clk_i(serial_clk_i),
      .clr_n_i(resetn_i),
      .d_i(1'b1),
      .q_o(link_rst_n)
   );

   // A high strobe arms the start of the next word without any clock edge.
   // strobe opens cycle
   always_ff @(posedge serial_clk_i or posedge serial_load_strobe_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         start_pending <= 1'b1;
      end else if (serial_load_strobe_i) begin
         start_pending <= 1'b1;
      end else begin
         start_pending <= 1'b0;
      end
   end

   // Next word and count; the first edge of a cycle drops any earlier bits.
   // shift data bits
   always_comb begin
      if (start_pending) begin
         next_shift_word = {11'h000, serial_data_in_i};
         next_clk_count = CNT_FIRST;
      end else begin
         next_shift_word = {shift_word[10:0], serial_data_in_i};
         next_clk_count = sat_inc(clk_count);
      end
   end

   // Shifting runs only while the strobe is low.
   // ignore when high
   always_ff @(posedge serial_clk_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         shift_word <= 12'h000;
         clk_count <= 2'h0;
      end else if (!serial_load_strobe_i) begin
         shift_word <= next_shift_word;
         clk_count <= next_clk_count;
      end
   end

   // The inverted strobe crosses into the core domain, so the cleared chain
   // matches the idle high strobe and no false rise follows reset.
   scm_sync u_strobe_sync (
      .clk_i(core_clk_i),
      .clr_n_i(core_rst_n),
      .d_i(~serial_load_strobe_i),
      .q_o(strobe_low_sync)
   );

   assign strobe_rise = strobe_low_prev & ~strobe_low_sync;

   // Word and count are frozen while the strobe is high, so reading them
   // after the synchronised rise is safe.
   // apply on rise
   always_comb begin
      next_dac_word = dac_word;
      next_update = 1'b0;
      if (strobe_rise && clk_count == MIN_LOAD_CLKS) begin
         next_dac_word = shift_word;
         next_update = 1'b1;
      end
   end

   // Core-side state registers.
   always_ff @(posedge core_clk_i or negedge core_rst_n) begin
      if (!core_rst_n) begin
         strobe_low_prev <= 1'b0;
         dac_word <= DAC_RST;
         update <= 1'b0;
      end else begin
         strobe_low_prev <= strobe_low_sync;
         dac_word <= next_dac_word;
         update <= next_update;
      end
   end

   // Output mode decoded without a clock from the pins and bit 11 of the applied word, so pin grounding needs no clock edge.
   // async ground force
   always_comb begin
      if (mode_source_select_i) begin
         mode = dac_word[PROG_GND_BIT] ? SCM_MODE_PROG_GND : SCM_MODE_NORMAL;
      end else if (ground_force_switch_i) begin
         mode = SCM_MODE_NORMAL;
      end else begin
         mode = SCM_MODE_PIN_GND;
      end
   end

   // Outputs; grounding overrides the applied word.
   assign analog_ground_o = (mode != SCM_MODE_NORMAL);
   assign control_dac_output_o = analog_ground_o ? DAC_GND : dac_word;
   assign dac_update_o = update;
endmodule

/* scm_top_assertions.sv */
/* Port checker for scm_top.
   Assumes it is bound to every scm_top instance. */
`timescale 1ns/1ps
module scm_top_chk(
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic serial_clk_i,
   input wire logic serial_load_strobe_i,
   input wire logic serial_data_in_i,
   input wire logic mode_source_select_i,
   input wire logic ground_force_switch_i,
   input wire logic [11:0] control_dac_output_o,
   input wire logic analog_ground_o,
   input wire logic dac_update_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   // An update pulse lasts one cycle and is followed by quiet cycles.
   sequence s_quiet;
      !dac_update_o [*4];
   endsequence
   property p_pulse;
      dac_update_o |=> s_quiet;
   endproperty
   a_pulse: assert property (p_pulse) else $error("update pulse too long");
   property p_after_rise;
      dac_update_o |-> $past(serial_load_strobe_i) && $past(serial_load_strobe_i, 2);
   endproperty
   a_after_rise: assert property (p_after_rise) else $error("update while strobe low");
   property p_word_hold;
      $changed(control_dac_output_o) && $stable(analog_ground_o) && !analog_ground_o |-> dac_update_o;
   endproperty
   a_word_hold: assert property (p_word_hold) else $error("word changed without update");
   property p_prog;
      mode_source_select_i && !analog_ground_o |-> !control_dac_output_o[11];
   endproperty
   a_prog: assert property (p_prog) else $error("programmed ground ignored");
   property p_norm;
      !mode_source_select_i && ground_force_switch_i |-> !analog_ground_o;
   endproperty
   a_norm: assert property (p_norm) else $error("grounded in normal mode");
   property p_gnd;
      !mode_source_select_i && !ground_force_switch_i |-> analog_ground_o && control_dac_output_o == 12'h000;
   endproperty
   a_gnd: assert property (p_gnd) else $error("pin ground not applied");
endmodule
bind scm_top scm_top_chk u_chk(.*);

/* scm_host_model.sv */
/* Host model driving the serial load link.
   Holds the strobe high 150 ns after each frame, then gives two serial clocks with it still high before the next frame. */
`timescale 1ns/1ps
module scm_host_model(
   output logic sclk_o = 1'b0,
   output logic strobe_o = 1'b1,
   output logic data_o = 1'b0
);
   // One 48 ns serial clock period carrying one bit.
   task automatic tick(input logic b);
      data_o = b;
      #12 sclk_o = 1'b1;
      #24 sclk_o = 1'b0;
      #12;
   endtask
   // Sends the low n bits of w, most significant first.
   task automatic send(input logic [11:0] w, input int n);
      tick(1'b1);
      tick(1'b0);
      strobe_o = 1'b0;
      #24;
      for (int i = n - 1; i >= 0; i--) begin
         tick(w[i]);
      end
      strobe_o = 1'b1;
      data_o = ~data_o;
      #150;
   endtask
endmodule

/* tb_top.sv */
/* Testbench for scm_top.
   Assumes scm_host_model drives the serial link. */
`timescale 1ns/1ps
module tb_top;
   logic clk = 0, rstn = 0, sel = 0, sw = 1, sclk, serial_load_strobe, serial_data_in, gnd, upd;
   logic [11:0] dac;
   int n_errors = 0, cmp_count = 0, n_upd = 0, cyc = 0;
   always #12.5 clk = ~clk;
   scm_host_model u_host(.sclk_o(sclk), .strobe_o(serial_load_strobe), .data_o(serial_data_in));
   scm_top DUT(.core_clk_i(clk), .resetn_i(rstn), .serial_clk_i(sclk), .serial_load_strobe_i(serial_load_strobe),
      .serial_data_in_i(serial_data_in), .mode_source_select_i(sel), .ground_force_switch_i(sw),
      .control_dac_output_o(dac), .analog_ground_o(gnd), .dac_update_o(upd));
   // Counts update pulses and cuts a hang short.
   always @(posedge clk) begin
      n_upd <= n_upd + (upd === 1'b1);
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         print_verdict();
      end
   end
   task automatic print_verdict;
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Sends n bits and checks how many updates followed.
   task automatic load(input logic [11:0] w, input int n, input int p);
      int b;
      b = n_upd;
      u_host.send(w, n);
      @(posedge clk);
      chk("update count", 13'(p), 13'(n_upd - b));
      chk("dac word", {1'b0, w}, {gnd, dac});
   endtask
   // Sets the mode pins and checks the outputs without waiting a clock.
   task automatic pins(input logic s, input logic w, input logic [12:0] exp);
      @(posedge clk);
      sel <= s;
      sw <= w;
      #1;
      chk("mode outputs", exp, {gnd, dac});
   endtask
   task automatic t_short;
      load(12'h5A3, 12, 1);
      u_host.send(12'h002, 2);
      chk("kept word", 13'h05A3, {gnd, dac});
      load(12'h005, 3, 1);
   endtask
   task automatic t_mode;
      load(12'h8F0, 12, 1);
      pins(1'b1, 1'b1, 13'h1000);
      pins(1'b0, 1'b0, 13'h1000);
      pins(1'b0, 1'b1, 13'h08F0);
      pins(1'b1, 1'b0, 13'h1000);
      load(12'h0F0, 12, 1);
      pins(1'b0, 1'b0, 13'h1000);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      t_short();
      t_mode();
      print_verdict();
   end
endmodule
